/* File: dual_timer_pkg.sv */
/*
 Shared constants for the dual timer/event counter: register indexes, control
 and interrupt-control bit positions, bus responses, modes and prescaler.
 Assumes a single 250 MHz clock domain and a 32-bit AXI4-Lite register port.
*/
`default_nettype none
package dual_timer_pkg;
    // Clock rate in MHz, kept for reference by derived counts
    localparam int CLK_MHZ = 250;
    // Printed offsets are register indexes; byte address is four times the index
    localparam int ADDR_W = 8;
    localparam int IDX_W = 6;
    localparam logic [IDX_W-1:0] IDX_TIMER8_COUNT_PRELOAD = 6'h0d;
    localparam logic [IDX_W-1:0] IDX_TIMER8_CONTROL = 6'h0e;
    localparam logic [IDX_W-1:0] IDX_TIMER16_HIGH_BYTE = 6'h0f;
    localparam logic [IDX_W-1:0] IDX_TIMER16_LOW_BYTE = 6'h10;
    localparam logic [IDX_W-1:0] IDX_TIMER16_CONTROL = 6'h11;
    localparam logic [IDX_W-1:0] IDX_INTERRUPT_CONTROL = 6'h20;
    // Control register fields
    localparam int CTRL_EDGE_BIT = 3;
    localparam int CTRL_EN_BIT = 4;
    localparam int CTRL_MODE_LSB = 6;
    localparam int CTRL_MODE_MSB = 7;
    // Interrupt control register fields
    localparam int INTERRUPT_CONTROL_REGISTER_IEN8_BIT = 0;
    localparam int INTERRUPT_CONTROL_REGISTER_IEN16_BIT = 1;
    localparam int INTERRUPT_CONTROL_REGISTER_FLAG8_BIT = 5;
    localparam int INTERRUPT_CONTROL_REGISTER_FLAG16_BIT = 6;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // System clock divided by four for the internal count clock
    localparam int PRESCALE_DIV = 4;
    localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE_DIV - 1);
    localparam logic [1:0] PRESCALE_ZERO = 2'h0;
    localparam logic [1:0] PRESCALE_STEP = 2'h1;

    typedef enum logic [1:0] {
        MODE_UNUSED = 2'h0,
        MODE_EVENT = 2'h1,
        MODE_TIMER = 2'h2,
        MODE_PULSE = 2'h3
    } mode_e;

    typedef enum logic {
        PW_WAIT = 1'h0,
        PW_MEAS = 1'h1
    } pw_state_e;

    // Word index of a byte address; misaligned addresses map to no register
    function automatic logic [IDX_W:0] reg_index(input logic [ADDR_W-1:0] addr);
        reg_index = (addr[1:0] == 2'h0) ? {1'b0, addr[ADDR_W-1:2]} : {1'b1, 6'h3f};
    endfunction

    // Control byte as read back; unimplemented bits are zero
    function automatic logic [7:0] ctrl_byte(input logic [1:0] mode, input logic en,
                                             input logic edge_sel);
        ctrl_byte = {mode, 1'b0, en, edge_sel, 3'h0};
    endfunction
endpackage
`default_nettype wire

/* File: counter_core.sv */
/*
 One up-counting timer/event counter of parameter width with preload, reload on
 overflow and single-shot pulse width measurement.
 Assumes the pin is synchronous to aclk and tick is a one-cycle pulse per four clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module counter_core
    import dual_timer_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] mode,
    input wire logic edge_sel,
    input wire logic count_enable,
    input wire logic ext_pin,
    input wire logic tick,
    input wire logic hold,
    input wire logic preload_wr,
    input wire logic [WIDTH-1:0] preload_data,
    output logic [WIDTH-1:0] count,
    output logic overflow,
    output logic measure_done
);
    localparam logic [WIDTH-1:0] ALL_ONES = '1;

    logic [WIDTH-1:0] count_reg, count_next;
    logic [WIDTH-1:0] preload_reg, preload_next;
    logic pin_prev_reg, pin_prev_next;
    logic ovf_reg, ovf_next;
    pw_state_e state_reg, state_next;
    logic active_edge, advance;

    always_comb begin
        // Falling edge when the select bit is set, rising otherwise
        active_edge = edge_sel ? (pin_prev_reg & ~ext_pin) : (~pin_prev_reg & ext_pin);
        case (mode_e'(mode))
            MODE_EVENT: advance = active_edge;
            MODE_TIMER: advance = tick;
            MODE_PULSE: advance = (state_reg == PW_MEAS) & tick;
            default: advance = 1'b0;
        endcase
        // Reads freeze the count clock; an event in that cycle is lost
        advance = advance & count_enable & ~hold;
        state_next = state_reg;
        measure_done = 1'b0;
        if (!count_enable || mode_e'(mode) != MODE_PULSE) begin
            state_next = PW_WAIT;
        end else begin
            case (state_reg)
                PW_WAIT: begin
                    if (active_edge) begin
                        state_next = PW_MEAS;
                    end
                end
                PW_MEAS: begin
                    // Back at the original level: one measurement only
                    if (ext_pin == edge_sel) begin
                        state_next = PW_WAIT;
                        measure_done = 1'b1;
                    end
                end
                default: state_next = PW_WAIT;
            endcase
        end
        preload_next = preload_wr ? preload_data : preload_reg;
        pin_prev_next = ext_pin;
        count_next = count_reg;
        ovf_next = 1'b0;
        if (preload_wr && !count_enable) begin
            count_next = preload_data;
        end else if (advance) begin
            if (count_reg == ALL_ONES) begin
                count_next = preload_next;
                ovf_next = 1'b1;
            end else begin
                count_next = count_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= '0;
            preload_reg <= '0;
            pin_prev_reg <= 1'b0;
            ovf_reg <= 1'b0;
            state_reg <= PW_WAIT;
        end else begin
            count_reg <= count_next;
            preload_reg <= preload_next;
            pin_prev_reg <= pin_prev_next;
            ovf_reg <= ovf_next;
            state_reg <= state_next;
        end
    end

    assign count = count_reg;
    assign overflow = ovf_reg;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_reload_on_wrap: assert property (ovf_reg |-> count_reg == preload_reg)
        else $error("Counter not reloaded on overflow");
    chk_disabled_stops: assert property (!count_enable && !preload_wr |=> $stable(count_reg))
        else $error("Counter moved while disabled");
    chk_stopped_preload: assert property (preload_wr && !count_enable
                                          |=> count_reg == $past(preload_data))
        else $error("Stopped counter not loaded by preload write");
    chk_hold_freezes: assert property (hold && !preload_wr |=> $stable(count_reg))
        else $error("Counter moved during read");
    chk_timer_rate: assert property (mode_e'(mode) == MODE_TIMER && !tick && !preload_wr
                                     |=> $stable(count_reg))
        else $error("Timer advanced without divided tick");
endmodule // counter_core
`default_nettype wire

/* File: dual_timer_event_counter.sv */
/*
 Two timer/event counters, 8-bit and 16-bit, behind an AXI4-Lite register slave,
 with interrupt request flags, interrupt enables and a wake-up pulse.
 Assumes timer pins are synchronous to aclk and the master keeps AXI4-Lite rules.
*/
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_event_counter
    import dual_timer_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic timer8_pin,
    input wire logic timer16_pin,
    output logic timer8_irq,
    output logic timer16_irq,
    output logic wakeup
);
    logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic [7:0] w_data_reg, w_data_next;
    logic w_lane_reg, w_lane_next;
    logic awready_reg, awready_next, wready_reg, wready_next;
    logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] mode8_reg, mode8_next, mode16_reg, mode16_next;
    logic edge8_reg, edge8_next, edge16_reg, edge16_next;
    logic en8_reg, en8_next, en16_reg, en16_next;
    logic ien8_reg, ien8_next, ien16_reg, ien16_next;
    logic flag8_reg, flag8_next, flag16_reg, flag16_next;
    logic [7:0] low_buf_reg, low_buf_next;
    logic [1:0] prescale_reg, prescale_next;
    logic irq8_reg, irq8_next, irq16_reg, irq16_next, wake_reg, wake_next;
    logic do_write, do_read, wr_ok;
    logic [IDX_W:0] wr_idx, rd_idx;
    logic hold8, hold16, tick, pre8_wr, pre16_wr;
    logic [7:0] count8;
    logic [15:0] count16;
    logic ovf8, ovf16, done8, done16;

    // Prescaler shared by both counters
    always_comb begin
        prescale_next = (prescale_reg == PRESCALE_LAST) ? PRESCALE_ZERO
                                                        : prescale_reg + PRESCALE_STEP;
        tick = (prescale_reg == PRESCALE_LAST);
    end

    // Bus channels
    always_comb begin
        do_write = aw_have_reg && w_have_reg && !bvalid_reg;
        do_read = arvalid && arready_reg;
        wr_idx = reg_index(aw_addr_reg);
        rd_idx = reg_index(araddr);
        wr_ok = do_write && w_lane_reg;
        aw_have_next = aw_have_reg;
        aw_addr_next = aw_addr_reg;
        w_have_next = w_have_reg;
        w_data_next = w_data_reg;
        w_lane_next = w_lane_reg;
        if (awvalid && awready_reg) begin
            aw_have_next = 1'b1;
            aw_addr_next = awaddr;
        end
        if (wvalid && wready_reg) begin
            w_have_next = 1'b1;
            w_data_next = wdata[7:0];
            w_lane_next = wstrb[0];
        end
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
        if (do_write) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            case (wr_idx)
                {1'b0, IDX_TIMER8_COUNT_PRELOAD}, {1'b0, IDX_TIMER8_CONTROL},
                {1'b0, IDX_TIMER16_HIGH_BYTE}, {1'b0, IDX_TIMER16_LOW_BYTE},
                {1'b0, IDX_TIMER16_CONTROL}, {1'b0, IDX_INTERRUPT_CONTROL}:
                    bresp_next = RESP_OKAY;
                default: bresp_next = RESP_SLVERR;
            endcase
        end
        // A new address or data item waits until the response has been taken
        awready_next = !aw_have_next && !bvalid_next;
        wready_next = !w_have_next && !bvalid_next;

        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        low_buf_next = low_buf_reg;
        hold8 = 1'b0;
        hold16 = 1'b0;
        if (wr_ok && wr_idx == {1'b0, IDX_TIMER16_LOW_BYTE}) begin
            low_buf_next = w_data_reg;
        end
        if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
        end
        if (do_read) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = 32'h0;
            case (rd_idx)
                {1'b0, IDX_TIMER8_COUNT_PRELOAD}: begin
                    rdata_next[7:0] = count8;
                    hold8 = 1'b1;
                end
                {1'b0, IDX_TIMER8_CONTROL}: rdata_next[7:0] = ctrl_byte(mode8_reg, en8_reg, edge8_reg);
                {1'b0, IDX_TIMER16_HIGH_BYTE}: begin
                    rdata_next[7:0] = count16[15:8];
                    low_buf_next = count16[7:0];
                    hold16 = 1'b1;
                end
                {1'b0, IDX_TIMER16_LOW_BYTE}: rdata_next[7:0] = low_buf_reg;
                {1'b0, IDX_TIMER16_CONTROL}: rdata_next[7:0] = ctrl_byte(mode16_reg, en16_reg, edge16_reg);
                {1'b0, IDX_INTERRUPT_CONTROL}: begin
                    rdata_next[INTERRUPT_CONTROL_REGISTER_IEN8_BIT] = ien8_reg;
                    rdata_next[INTERRUPT_CONTROL_REGISTER_IEN16_BIT] = ien16_reg;
                    rdata_next[INTERRUPT_CONTROL_REGISTER_FLAG8_BIT] = flag8_reg;
                    rdata_next[INTERRUPT_CONTROL_REGISTER_FLAG16_BIT] = flag16_reg;
                end
                default: rresp_next = RESP_SLVERR;
            endcase
        end
        // A new read address only while no read data is pending; arready is low during reset and rises one cycle after it
        arready_next = !rvalid_next;
    end

    // Control, flags and outputs
    always_comb begin
        pre8_wr = wr_ok && wr_idx == {1'b0, IDX_TIMER8_COUNT_PRELOAD};
        pre16_wr = wr_ok && wr_idx == {1'b0, IDX_TIMER16_HIGH_BYTE};
        mode8_next = mode8_reg;
        edge8_next = edge8_reg;
        en8_next = en8_reg;
        mode16_next = mode16_reg;
        edge16_next = edge16_reg;
        en16_next = en16_reg;
        // Hardware clear only comes from pulse mode; software write wins to re-arm
        if (done8) begin
            en8_next = 1'b0;
        end
        if (done16) begin
            en16_next = 1'b0;
        end
        if (wr_ok && wr_idx == {1'b0, IDX_TIMER8_CONTROL}) begin
            mode8_next = w_data_reg[CTRL_MODE_MSB:CTRL_MODE_LSB];
            edge8_next = w_data_reg[CTRL_EDGE_BIT];
            en8_next = w_data_reg[CTRL_EN_BIT];
        end
        if (wr_ok && wr_idx == {1'b0, IDX_TIMER16_CONTROL}) begin
            mode16_next = w_data_reg[CTRL_MODE_MSB:CTRL_MODE_LSB];
            edge16_next = w_data_reg[CTRL_EDGE_BIT];
            en16_next = w_data_reg[CTRL_EN_BIT];
        end
        ien8_next = ien8_reg;
        ien16_next = ien16_reg;
        flag8_next = flag8_reg;
        flag16_next = flag16_reg;
        if (wr_ok && wr_idx == {1'b0, IDX_INTERRUPT_CONTROL}) begin
            ien8_next = w_data_reg[INTERRUPT_CONTROL_REGISTER_IEN8_BIT];
            ien16_next = w_data_reg[INTERRUPT_CONTROL_REGISTER_IEN16_BIT];
            flag8_next = w_data_reg[INTERRUPT_CONTROL_REGISTER_FLAG8_BIT];
            flag16_next = w_data_reg[INTERRUPT_CONTROL_REGISTER_FLAG16_BIT];
        end
        // Overflow set beats a clear in the same cycle
        flag8_next = flag8_next | ovf8;
        flag16_next = flag16_next | ovf16;
        irq8_next = flag8_next & ien8_next;
        irq16_next = flag16_next & ien16_next;
        wake_next = ovf8 | ovf16;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_have_reg <= 1'b0;
            w_data_reg <= 8'h0;
            w_lane_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h0;
            mode8_reg <= MODE_UNUSED;
            mode16_reg <= MODE_UNUSED;
            edge8_reg <= 1'b0;
            edge16_reg <= 1'b0;
            en8_reg <= 1'b0;
            en16_reg <= 1'b0;
            ien8_reg <= 1'b0;
            ien16_reg <= 1'b0;
            flag8_reg <= 1'b0;
            flag16_reg <= 1'b0;
            low_buf_reg <= 8'h0;
            prescale_reg <= PRESCALE_ZERO;
            irq8_reg <= 1'b0;
            irq16_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_next;
            aw_addr_reg <= aw_addr_next;
            w_have_reg <= w_have_next;
            w_data_reg <= w_data_next;
            w_lane_reg <= w_lane_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            mode8_reg <= mode8_next;
            mode16_reg <= mode16_next;
            edge8_reg <= edge8_next;
            edge16_reg <= edge16_next;
            en8_reg <= en8_next;
            en16_reg <= en16_next;
            ien8_reg <= ien8_next;
            ien16_reg <= ien16_next;
            flag8_reg <= flag8_next;
            flag16_reg <= flag16_next;
            low_buf_reg <= low_buf_next;
            prescale_reg <= prescale_next;
            irq8_reg <= irq8_next;
            irq16_reg <= irq16_next;
            wake_reg <= wake_next;
        end
    end

    counter_core #(.WIDTH(8)) timer8 (
        .aclk(aclk),
        .aresetn(aresetn),
        .mode(mode8_reg),
        .edge_sel(edge8_reg),
        .count_enable(en8_reg),
        .ext_pin(timer8_pin),
        .tick(tick),
        .hold(hold8),
        .preload_wr(pre8_wr),
        .preload_data(w_data_reg),
        .count(count8),
        .overflow(ovf8),
        .measure_done(done8)
    );

    counter_core #(.WIDTH(16)) timer16 (
        .aclk(aclk),
        .aresetn(aresetn),
        .mode(mode16_reg),
        .edge_sel(edge16_reg),
        .count_enable(en16_reg),
        .ext_pin(timer16_pin),
        .tick(tick),
        .hold(hold16),
        .preload_wr(pre16_wr),
        .preload_data({w_data_reg, low_buf_reg}),
        .count(count16),
        .overflow(ovf16),
        .measure_done(done16)
    );

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;
    assign timer8_irq = irq8_reg;
    assign timer16_irq = irq16_reg;
    assign wakeup = wake_reg;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_flag_on_overflow: assert property (ovf16 |=> flag16_reg)
        else $error("Overflow did not set timer16 flag");
    chk_ctrl_unused_zero: assert property (do_read && rd_idx == {1'b0, IDX_TIMER8_CONTROL}
                                           |=> rdata_reg[2:0] == 3'h0 && !rdata_reg[5])
        else $error("Unused control bits read nonzero");
    chk_pulse_end_clears: assert property (done16 && !(wr_ok && wr_idx == {1'b0, IDX_TIMER16_CONTROL})
                                           |=> !en16_reg)
        else $error("Pulse end did not clear enable");
    chk_irq_gated: assert property (!ien8_reg |-> !timer8_irq)
        else $error("Interrupt raised while disabled");
    chk_wake_on_ovf: assert property ((ovf8 || ovf16) |=> wakeup ##1 (!wakeup || $past(ovf8 || ovf16)))
        else $error("No wake-up after overflow");
    chk_high_read_latch: assert property (do_read && rd_idx == {1'b0, IDX_TIMER16_HIGH_BYTE}
                                          |=> low_buf_reg == $past(count16[7:0]))
        else $error("Low byte not latched on high read");

    cov_timer8_overflow: cover property (ovf8 ##[1:8] rvalid_reg);
    cov_pulse_measure: cover property (mode16_reg == MODE_PULSE && done16);
    cov_write_then_read: cover property (bvalid_reg ##[1:10] rvalid_reg);
endmodule // dual_timer_event_counter
`default_nettype wire

/* File: pin_source.sv */
/* Drives the two counter input pins from the bench.
   Assumes pins are sampled on rising edges of aclk. */
`timescale 1ns/1ps
`default_nettype none
module pin_source (
    input wire logic aclk,
    output logic pin8,
    output logic pin16
);
    initial begin
        pin8 = 1'b0;
        pin16 = 1'b0;
    end
    // High pulse of w cycles then w low; idle low keeps edges countable
    task automatic pulse(input logic sel, input int w);
        @(posedge aclk);
        if (sel) pin16 <= 1'b1;
        else pin8 <= 1'b1;
        repeat (w) @(posedge aclk);
        if (sel) pin16 <= 1'b0;
        else pin8 <= 1'b0;
        repeat (w) @(posedge aclk);
    endtask
endmodule // pin_source
`default_nettype wire

/* File: dual_timer_event_counter_tb.sv */
/* Self-checking bench for the dual timer/event counter.
   Assumes a 250 MHz clock and AXI4-Lite byte addresses of index times four. */
`timescale 1ns/1ps
`default_nettype none
module dual_timer_event_counter_tb;
    import dual_timer_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, t8_irq, t16_irq, wakeup, pin8, pin16;
    int bad_count = 0, total_checks = 0, wake_seen = 0;
    logic [31:0] d, e;
    logic [1:0] r, br;
    localparam logic [7:0] a_p8 = {IDX_TIMER8_COUNT_PRELOAD, 2'b00};
    localparam logic [7:0] a_c8 = {IDX_TIMER8_CONTROL, 2'b00};
    localparam logic [7:0] a_hi = {IDX_TIMER16_HIGH_BYTE, 2'b00};
    localparam logic [7:0] a_lo = {IDX_TIMER16_LOW_BYTE, 2'b00};
    localparam logic [7:0] a_c16 = {IDX_TIMER16_CONTROL, 2'b00};
    localparam logic [7:0] a_ic = {IDX_INTERRUPT_CONTROL, 2'b00};
    dual_timer_event_counter u_dual_timer_event_counter (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .timer8_pin(pin8), .timer16_pin(pin16),
        .timer8_irq(t8_irq), .timer16_irq(t16_irq), .wakeup(wakeup));
    pin_source u_pin_source (.aclk(aclk), .pin8(pin8), .pin16(pin16));
    initial forever #2 aclk = ~aclk;
    always @(posedge aclk) if (wakeup === 1'b1) wake_seen++;
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic ta, tw;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        ta = 0;
        tw = 0;
        // Each channel is released only at the edge that takes it
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (awvalid && awready) begin ta = 1; awvalid <= 0; end
            if (wvalid && wready) begin tw = 1; wvalid <= 0; end
        end
        while (!bvalid) @(posedge aclk);
        br = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        while (!rvalid) @(posedge aclk);
        v = rdata;
        rs = rresp;
        rready <= 0;
    endtask
    task automatic t_regs;
        rd(a_c8, d, r); check("ctrl8 reset", d, 0);
        rd(8'hfc, d, r); check("unmapped resp", r, RESP_SLVERR);
        wr(8'hfc, 8'h00); check("unmapped bresp", br, RESP_SLVERR);
        wr(a_c8, 8'hff); check("ctrl8 bresp", br, RESP_OKAY);
        rd(a_c8, d, r); check("ctrl8 bits", d, 32'hd8);
        wr(a_c8, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_buffer;
        wr(a_lo, 8'h34);
        wr(a_hi, 8'h12);
        rd(a_hi, d, r); check("t16 high", d, 32'h12);
        rd(a_lo, d, r); check("t16 low", d, 32'h34);
        $display("test buffer done");
    endtask
    task automatic t_event;
        wr(a_p8, 8'h10);
        wr(a_c8, 8'h50);
        wr(a_c16, 8'h58);
        repeat (3) begin
            u_pin_source.pulse(0, 8);
            u_pin_source.pulse(1, 8);
        end
        wr(a_c8, 8'h00);
        wr(a_c16, 8'h00);
        rd(a_p8, d, r); check("t8 events", d, 32'h13);
        rd(a_hi, d, r);
        rd(a_lo, d, r); check("t16 fall events", d, 32'h37);
        $display("test event done");
    endtask
    task automatic t_timer;
        wr(a_p8, 8'hfd);
        wr(a_c8, 8'h90);
        repeat (40) @(posedge aclk);
        rd(a_ic, d, r); check("flags", d[6:5], 2'b01);
        check("irq masked", t8_irq, 0);
        wr(a_ic, 8'h63);
        repeat (2) @(posedge aclk);
        check("irq on", t8_irq, 1);
        check("irq16 on", t16_irq, 1);
        rd(a_c8, d, r); check("enable kept", d, 32'h90);
        rd(a_p8, d, r); check("reload range", 32'(d >= 32'hfd), 1);
        wr(a_c8, 8'h00);
        wr(a_ic, 8'h00);
        check("wakeup seen", 32'(wake_seen > 0), 1);
        $display("test timer done");
    endtask
    task automatic t_pulse;
        wr(a_p8, 8'h00);
        wr(a_c8, 8'hd0);
        u_pin_source.pulse(0, 40);
        rd(a_c8, d, r); check("pw self stop", d, 32'hc0);
        rd(a_p8, e, r); check("pw width", 32'(e >= 9 && e <= 11), 1);
        u_pin_source.pulse(0, 40);
        rd(a_p8, d, r); check("pw held", d, e);
        $display("test pulse done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #100us;
        bad_count++;
        results;
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        t_regs;
        t_buffer;
        t_event;
        t_timer;
        t_pulse;
        results;
    end
endmodule // dual_timer_event_counter_tb
`default_nettype wire
